// [rtl/asfp_cfg.svh]
// Constants for the asynchronous slave FIFO port, both ends.
// Assumes a single 200 MHz ref_clk; strobe pins sampled synchronously.
// Summary of operation
// - Chip select with or before read strobe
// - Output enable drives prefetched previous data
// - Read strobe presents current FIFO entry
// - Read data only visible with output enable
// - Output enable may be tied to read strobe
// - Drive entry first, then advance read pointer
// - Chip select with or before write strobe
// - Capture on write strobe release, post-increment
// - Flags update after write strobe release
// - Never write strobe and packet end together
// - Packet end commits bytes already written
// - FIFO select stable during packet end
// - Chip select may be tied active
`ifndef ASFP_CFG_SVH
`define ASFP_CFG_SVH
`define ASFP_CLK_PERIOD_NS 5
`define ASFP_STROBE_NS     50
`define ASFP_STROBE_CYC    ((`ASFP_STROBE_NS + `ASFP_CLK_PERIOD_NS - 1) \
                            / `ASFP_CLK_PERIOD_NS)
`define ASFP_DATA_W        8
`define ASFP_SEL_W         2
`define ASFP_DEPTH         16
`endif

// [rtl/asfp_pkg.sv]
// Types shared by both ends of the slave FIFO port.
// Assumes asfp_cfg.svh for widths.
`include "asfp_cfg.svh"
package asfp_pkg;
  typedef logic [`ASFP_DATA_W-1:0] asfp_data_t;
  typedef logic [`ASFP_SEL_W-1:0]  asfp_sel_t;
  typedef enum logic [2:0] {
    ASFP_IDLE   = 3'b000,
    ASFP_RDLOW  = 3'b001,
    ASFP_RDHIGH = 3'b010,
    ASFP_WRLOW  = 3'b011,
    ASFP_WRHIGH = 3'b100,
    ASFP_PELOW  = 3'b101,
    ASFP_PEHIGH = 3'b110
  } asfp_state_t;
endpackage : asfp_pkg

// [rtl/asfp_if.sv]
// Pin bundle between the slave FIFO device and its external master.
// The data bus is resolved here from the two output enables.
`timescale 1ns/1ps
`include "asfp_cfg.svh"
interface asfp_if;
  logic                    fifo_chip_select_n;
  logic                    fifo_output_enable_n;
  logic                    fifo_read_strobe_n;
  logic                    fifo_write_strobe_n;
  logic                    packet_commit_strobe_n;
  logic [`ASFP_SEL_W-1:0]  fifo_select;
  logic [`ASFP_DATA_W-1:0] devData;
  logic                    devDataOe;
  logic [`ASFP_DATA_W-1:0] mstData;
  logic                    mstDataOe;
  logic [`ASFP_DATA_W-1:0] busData;
  logic                    fifoEmpty;
  logic                    fifoFull;
  // Bus level: whoever enables wins; collision reads as unknown
  assign busData = devDataOe ? (mstDataOe ? 'x : devData)
                             : (mstDataOe ? mstData : 'x);
  modport device (input fifo_chip_select_n, fifo_output_enable_n,
    fifo_read_strobe_n, fifo_write_strobe_n, packet_commit_strobe_n,
    fifo_select, busData, output devData, devDataOe, fifoEmpty, fifoFull);
  modport master (output fifo_chip_select_n, fifo_output_enable_n,
    fifo_read_strobe_n, fifo_write_strobe_n, packet_commit_strobe_n,
    fifo_select, mstData, mstDataOe, input busData, fifoEmpty, fifoFull);
endinterface : asfp_if

// [rtl/asfp_device.sv]
// Device end: one FIFO per select, filled by the core and read to pins; pin writes drain to the core.
// Assumes master keeps strobe widths; pins synchronous to ref_clk.
`timescale 1ns/1ps
`include "asfp_cfg.svh"
module asfp_device
  import asfp_pkg::*;
#(
  parameter int DEPTH = `ASFP_DEPTH
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Pins
  asfp_if.device                pins,
  // Core side: fill for reads
  input  wire asfp_data_t       coreInData,
  input  wire asfp_sel_t        coreInSel,
  input  wire logic             coreInValid,
  output logic                  coreInReady,
  // Core side: drain of written data
  output asfp_data_t            coreOutData,
  output asfp_sel_t             coreOutSel,
  output logic                  coreOutValid,
  output logic                  coreOutCommit,
  input  wire logic             coreOutReady
);
  localparam int AW = $clog2(DEPTH);
  localparam int NF = 1 << `ASFP_SEL_W;

  asfp_data_t        mem [NF][DEPTH];
  logic [AW:0]       wrPtr_q [NF];
  logic [AW:0]       rdPtr_q [NF];
  logic              rdSeen_q, wrSeen_q, peSeen_q;
  asfp_data_t        dout_q;
  logic              oe_q, empty_q, full_q;
  // Two-entry output buffer
  logic [`ASFP_DATA_W+`ASFP_SEL_W:0] buf_q [2];
  logic [1:0]        bufCnt_q;
  logic              outValid_q;

  function automatic logic isEmpty(logic [AW:0] w, logic [AW:0] r);
    return w == r;
  endfunction : isEmpty

  // Pointer step; the extra top bit tells full from empty
  function automatic logic [AW:0] ptrNext(logic [AW:0] p);
    return p + 1'b1;
  endfunction : ptrNext

  wire asfp_sel_t sel   = pins.fifo_select;
  wire logic csOn       = !pins.fifo_chip_select_n;
  wire logic rdOn       = csOn && !pins.fifo_read_strobe_n;
  wire logic wrOn       = csOn && !pins.fifo_write_strobe_n;
  wire logic peOn       = csOn && !pins.packet_commit_strobe_n;
  wire logic wrRelease  = wrSeen_q && !wrOn;
  wire logic peRelease  = peSeen_q && !peOn;
  wire logic bufFull    = bufCnt_q == 2'd2;
  // Write captured only when buffer has room; master sees full flag
  wire logic doWrite    = wrRelease && !bufFull;
  wire logic doRead     = rdOn && !rdSeen_q &&
                          !isEmpty(wrPtr_q[sel], rdPtr_q[sel]);
  wire logic popBuf     = coreOutValid && coreOutReady;
  wire logic pushBuf    = doWrite || (peRelease && !bufFull);
  wire logic coreFill   = coreInValid && coreInReady;
  // Next occupancy drives flag and valid, so neither lags a pop
  wire logic [1:0] bufCntNext = bufCnt_q + {1'b0, pushBuf}
                                - {1'b0, popBuf};
  wire logic [`ASFP_DATA_W+`ASFP_SEL_W:0] bufWord =
    {peRelease, sel, pins.busData};

  // Edge memory of strobes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdSeen_q <= 1'b0;
      wrSeen_q <= 1'b0;
      peSeen_q <= 1'b0;
    end else begin
      rdSeen_q <= rdOn;
      wrSeen_q <= wrOn;
      peSeen_q <= peOn;
    end
  end

  // Read FIFO storage and pointers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NF; i++) begin
        wrPtr_q[i] <= '0;
        rdPtr_q[i] <= '0;
      end
    end else begin
      if (coreFill) begin
        mem[coreInSel][wrPtr_q[coreInSel][AW-1:0]] <= coreInData;
        wrPtr_q[coreInSel] <= ptrNext(wrPtr_q[coreInSel]);
      end
      if (doRead)
        rdPtr_q[sel] <= ptrNext(rdPtr_q[sel]); // after driving
    end
  end

  // Data pin: prefetched entry, refreshed only by a read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= '0;
      oe_q   <= 1'b0;
    end else begin
      if (doRead)
        dout_q <= mem[sel][rdPtr_q[sel][AW-1:0]];
      oe_q <= !pins.fifo_output_enable_n;
    end
  end
  assign pins.devData   = dout_q;
  assign pins.devDataOe = oe_q;

  // Flags follow write release and core traffic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      empty_q <= 1'b1;
      full_q  <= 1'b0;
    end else begin
      empty_q <= isEmpty(wrPtr_q[sel], rdPtr_q[sel]);
      full_q  <= bufCntNext == 2'd2;
    end
  end
  assign pins.fifoEmpty = empty_q;
  assign pins.fifoFull  = full_q;
  assign coreInReady = 1'b1;

  // Output buffer: commit marker travels as an empty word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bufCnt_q   <= 2'd0;
      outValid_q <= 1'b0;
      buf_q[0]   <= '0;
      buf_q[1]   <= '0;
    end else begin
      if (popBuf)
        buf_q[0] <= buf_q[1];
      if (pushBuf) begin
        // data sampled on release, then slot advances
        if (bufCnt_q == 2'd0 || (bufCnt_q == 2'd1 && popBuf))
          buf_q[0] <= bufWord;
        else
          buf_q[1] <= bufWord;
      end
      bufCnt_q   <= bufCntNext;
      outValid_q <= bufCntNext != 2'd0;
    end
  end
  assign coreOutValid  = outValid_q;
  assign coreOutData   = buf_q[0][`ASFP_DATA_W-1:0];
  assign coreOutSel    = buf_q[0][`ASFP_DATA_W +: `ASFP_SEL_W];
  assign coreOutCommit = buf_q[0][`ASFP_DATA_W+`ASFP_SEL_W];
endmodule : asfp_device

// [rtl/asfp_master.sv]
// Master end: drives strobes with 50 ns widths from simple commands.
// Assumes device pins synchronous to ref_clk.
`timescale 1ns/1ps
`include "asfp_cfg.svh"
module asfp_master
  import asfp_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Pins
  asfp_if.master          pins,
  // Commands
  input  wire logic       cmdValid,
  input  wire logic [1:0] cmdOp,
  input  wire asfp_sel_t  cmdSel,
  input  wire asfp_data_t cmdData,
  output logic            cmdReady,
  // Read result
  output asfp_data_t      rspData,
  output logic            rspValid
);
  asfp_state_t st_q, st_d;
  logic [7:0]  cnt_q;
  asfp_sel_t   sel_q;
  asfp_data_t  dat_q, rsp_q;
  logic        rspV_q;
  logic        rdN_q, wrN_q, peN_q, mstOe_q, rdy_q;
  wire logic   done  = cnt_q == 8'(`ASFP_STROBE_CYC - 1);
  wire logic   take  = cmdValid && rdy_q;
  wire logic   rdEnd = st_q == ASFP_RDLOW && done;

  // Next phase; each strobe low and high phase lasts the minimum pulse width, idle until a command
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ASFP_IDLE: begin
        if (take && cmdOp == 2'd0)
          st_d = ASFP_RDLOW;
        else if (take && cmdOp == 2'd1)
          st_d = ASFP_WRLOW;
        else if (take)
          st_d = ASFP_PELOW;
      end
      ASFP_RDLOW:  if (done) st_d = ASFP_RDHIGH;
      ASFP_WRLOW:  if (done) st_d = ASFP_WRHIGH;
      ASFP_PELOW:  if (done) st_d = ASFP_PEHIGH;
      ASFP_RDHIGH, ASFP_WRHIGH, ASFP_PEHIGH:
        if (done) st_d = ASFP_IDLE; // inactive width kept
      default: st_d = ASFP_IDLE;
    endcase
  end

  // Phase register, width counter and command capture
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ASFP_IDLE;
      cnt_q <= 8'h00;
      sel_q <= '0;
      dat_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= (take || done) ? 8'h00 : cnt_q + 8'h01;
      if (take) begin
        sel_q <= cmdSel; // held through strobe
        dat_q <= cmdData;
      end
    end
  end

  // Read data taken at the last strobe-low edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_q  <= '0;
      rspV_q <= 1'b0;
    end else begin
      rspV_q <= rdEnd;
      if (rdEnd)
        rsp_q <= pins.busData;
    end
  end

  // Pins from next phase: glitch free, same timing as the phase
  // Ready held low while the device buffer is full, so no word drops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdN_q   <= 1'b1;
      wrN_q   <= 1'b1;
      peN_q   <= 1'b1;
      mstOe_q <= 1'b0;
      rdy_q   <= 1'b1;
    end else begin
      rdN_q   <= st_d != ASFP_RDLOW;
      wrN_q   <= st_d != ASFP_WRLOW;
      peN_q   <= st_d != ASFP_PELOW;
      mstOe_q <= st_d == ASFP_WRLOW || st_d == ASFP_WRHIGH;
      rdy_q   <= st_d == ASFP_IDLE && !pins.fifoFull;
    end
  end
  // Chip select tied active OE shares read
  assign pins.fifo_chip_select_n     = 1'b0;
  assign pins.fifo_read_strobe_n     = rdN_q;
  assign pins.fifo_output_enable_n   = rdN_q;
  assign pins.fifo_write_strobe_n    = wrN_q;
  assign pins.packet_commit_strobe_n = peN_q;
  assign pins.fifo_select            = sel_q;
  assign pins.mstData                = dat_q;
  assign pins.mstDataOe              = mstOe_q;
  assign cmdReady = rdy_q;
  assign rspData  = rsp_q;
  assign rspValid = rspV_q;
endmodule : asfp_master

// [verif/asfp_props.sv]
// Pin checker for the slave FIFO port between both design ends.
// Assumes pins sampled on ref_clk and chip select held active.
`timescale 1ns/1ps
`include "asfp_cfg.svh"
module asfp_props (
  // Clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  // Strobes and select
  input wire logic                    fifo_chip_select_n,
  input wire logic                    fifo_output_enable_n,
  input wire logic                    fifo_read_strobe_n,
  input wire logic                    fifo_write_strobe_n,
  input wire logic                    packet_commit_strobe_n,
  input wire logic [`ASFP_SEL_W-1:0]  fifo_select,
  // Device drive
  input wire logic [`ASFP_DATA_W-1:0] devData,
  input wire logic                    devDataOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Whole write strobe: ten low cycles, then release
  sequence s_wr_low;
    !fifo_write_strobe_n [*8] ##1 !fifo_write_strobe_n [*2];
  endsequence
  property p_wr_pulse;
    $fell(fifo_write_strobe_n) |-> s_wr_low ##1 fifo_write_strobe_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe width wrong");
  property p_oe_on;
    $fell(fifo_output_enable_n) |-> ##[1:2] devDataOe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("bus not driven after output enable");
  property p_oe_off;
    $rose(fifo_output_enable_n) |-> ##[1:2] !devDataOe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("bus still driven after output enable release");
  // Settled high enable must never drive, or write data collides
  property p_quiet;
    fifo_output_enable_n && $past(fifo_output_enable_n)
      && $past(fifo_output_enable_n, 2) |-> !devDataOe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("bus driven without output enable");
  property p_hold;
    !fifo_read_strobe_n && !$past(fifo_read_strobe_n, 3)
      && !$past(fifo_read_strobe_n, 2) |-> $stable(devData);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data moved while strobe held");
  property p_cs;
    !fifo_read_strobe_n || !fifo_write_strobe_n |-> !fifo_chip_select_n;
  endproperty
  a_cs: assert property (p_cs)
    else $error("strobe without chip select");
  property p_excl;
    fifo_write_strobe_n || packet_commit_strobe_n;
  endproperty
  a_excl: assert property (p_excl)
    else $error("write and packet end together");
  property p_gap;
    $rose(fifo_write_strobe_n) |-> packet_commit_strobe_n [*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("packet end too soon after write");
  property p_sel;
    !packet_commit_strobe_n && !$past(packet_commit_strobe_n)
      |-> $stable(fifo_select);
  endproperty
  a_sel: assert property (p_sel)
    else $error("select moved during packet end");
endmodule : asfp_props

// [verif/async_slave_fifo_port_tb_top.sv]
// Bench joining device and master ends through the pin interface.
// Assumes 200 MHz ref_clk and the command timing of the master end.
`timescale 1ns/1ps
`include "asfp_cfg.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  failures++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module async_slave_fifo_port_tb_top;
  import asfp_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cmdValid = 1'b0, coreInValid = 1'b0, coreOutReady = 1'b0;
  logic [1:0] cmdOp = 2'h0;
  asfp_sel_t  cmdSel = 2'h0, coreInSel = 2'h0, coreOutSel;
  asfp_data_t cmdData = 8'h00, coreInData = 8'h00, coreOutData, rspData;
  logic       cmdReady, rspValid, coreInReady, coreOutValid, coreOutCommit;
  logic [10:0] outQ[$];
  int         failures = 0, samples_checked = 0, cycles = 0;
  asfp_if i_asfp_if ();
  asfp_device i_asfp_device (.ref_clk(ref_clk), .rst_n(rst_n),
    .pins(i_asfp_if), .coreInData(coreInData), .coreInSel(coreInSel),
    .coreInValid(coreInValid), .coreInReady(coreInReady),
    .coreOutData(coreOutData), .coreOutSel(coreOutSel),
    .coreOutValid(coreOutValid), .coreOutCommit(coreOutCommit),
    .coreOutReady(coreOutReady));
  asfp_master i_asfp_master (.ref_clk(ref_clk), .rst_n(rst_n),
    .pins(i_asfp_if), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSel(cmdSel),
    .cmdData(cmdData), .cmdReady(cmdReady), .rspData(rspData),
    .rspValid(rspValid));
  asfp_props i_asfp_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .fifo_chip_select_n(i_asfp_if.fifo_chip_select_n),
    .fifo_output_enable_n(i_asfp_if.fifo_output_enable_n),
    .fifo_read_strobe_n(i_asfp_if.fifo_read_strobe_n),
    .fifo_write_strobe_n(i_asfp_if.fifo_write_strobe_n),
    .packet_commit_strobe_n(i_asfp_if.packet_commit_strobe_n),
    .fifo_select(i_asfp_if.fifo_select), .devData(i_asfp_if.devData),
    .devDataOe(i_asfp_if.devDataOe));
  // Clock, drained-word log and hang guard
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (coreOutValid && coreOutReady)
      outQ.push_back({coreOutCommit, coreOutSel, coreOutData});
    cycles++;
    if (cycles == 2000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step
  // One command; waits for idle again, keeps any read answer
  task automatic run_cmd(input logic [1:0] op, input asfp_data_t d,
                         output asfp_data_t r);
    int n;
    for (n = 0; n < 40 && cmdReady !== 1'b1; n++) step();
    cmdValid = 1'b1;
    cmdOp = op;
    cmdData = d;
    step();
    cmdValid = 1'b0;
    for (n = 0; n < 40 && cmdReady !== 1'b1; n++) begin
      step();
      if (rspValid === 1'b1) r = rspData;
    end
  endtask : run_cmd
  task automatic t_read();
    asfp_data_t r;
    cmdSel = 2'h1;
    coreInValid = 1'b1;
    coreInSel = 2'h1;
    coreInData = 8'ha5;
    step();
    coreInData = 8'h3c;
    step();
    coreInValid = 1'b0;
    run_cmd(2'h0, 8'h00, r);
    `CHK(r, 8'ha5)
    `CHK(i_asfp_if.fifoEmpty, 1'b0)
    run_cmd(2'h0, 8'h00, r);
    `CHK(r, 8'h3c)
    run_cmd(2'h0, 8'h00, r); // Empty now: prior data repeats
    `CHK(r, 8'h3c)
    `CHK(i_asfp_if.fifoEmpty, 1'b1)
    `CHK(i_asfp_if.devDataOe, 1'b0)
    $display("test read done");
  endtask : t_read
  // Stalled drain fills the buffer, then a short packet is committed
  task automatic t_write();
    asfp_data_t r;
    cmdSel = 2'h2;
    run_cmd(2'h1, 8'h11, r);
    run_cmd(2'h1, 8'h22, r);
    `CHK(i_asfp_if.fifoFull, 1'b1)
    `CHK(cmdReady, 1'b0)
    coreOutReady = 1'b1;
    step();
    step();
    `CHK(i_asfp_if.fifoFull, 1'b0)
    run_cmd(2'h1, 8'h33, r);
    run_cmd(2'h1, 8'h44, r);
    run_cmd(2'h2, 8'h00, r);
    repeat (4) step();
    `CHK(outQ.size(), 5)
    for (int i = 0; i < 4; i++)
      `CHK(outQ[i], {3'h2, 8'(8'h11 * (i + 1))})
    `CHK(outQ[4][10:8], 3'h6)
    $display("test write done");
  endtask : t_write
  task automatic print_verdict();
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_read();
    t_write();
    print_verdict();
  end
endmodule : async_slave_fifo_port_tb_top
